// ==== design/psrw_pkg.sv ====
package psrw_pkg;

  // ****************************************
  // widths and field positions
  // ****************************************
  localparam int DATA_ADDR_W   = 16;
  localparam int PAGE_W        = 10;
  localparam int PROG_ADDR_W   = 23;
  localparam int WORD_W        = 16;
  localparam int PAGE_EN_BIT   = 9;
  localparam int PAGE_WSEL_BIT = 8;
  localparam int WINDOW_BIT    = 15;
  localparam int PAGE_LOW_W    = 8;

  // ****************************************
  // reset values and page bounds
  // ****************************************
  localparam logic [PAGE_W-1:0] PAGE_RST       = 10'h000;
  localparam logic [PAGE_W-1:0] PAGE_FIRST     = 10'h200;
  localparam logic [PAGE_W-1:0] PAGE_LAST      = 10'h3ff;
  localparam logic [PAGE_W-1:0] PAGE_UPPER_LO  = 10'h300;
  localparam logic [PAGE_W-1:0] PAGE_LOWER_HI  = 10'h2ff;

  // ****************************************
  // added instruction cycles
  // ****************************************
  localparam logic [1:0] EXTRA_MOVE  = 2'h1;
  localparam logic [1:0] EXTRA_OTHER = 2'h2;
  localparam logic [1:0] EXTRA_NONE  = 2'h0;

  // ****************************************
  // request and answer carriers
  // ****************************************
  typedef struct packed {
    logic                   valid;
    logic                   isWrite;
    logic                   isMove;
    logic                   inRepeat;
    logic                   repFirst;
    logic                   repLast;
    logic                   repIntExit;
    logic                   repIntEntry;
    logic [DATA_ADDR_W-1:0] addr;
  } psrw_req_t;

  typedef struct packed {
    logic                   toProgram;
    logic                   toData;
    logic                   addrTrap;
    logic                   upperWord;
    logic [1:0]             extraCycles;
    logic [PROG_ADDR_W-1:0] progAddr;
    logic [DATA_ADDR_W-1:0] dataAddr;
  } psrw_rsp_t;

  typedef enum logic [2:0] {
    PSRW_IDLE = 3'b001,
    PSRW_HOLD = 3'b010,
    PSRW_DONE = 3'b100
  } psrw_state_t;

endpackage

// ==== design/psrw_window.sv ====
`timescale 1ns/100ps
// Behaviour
// - program route needs address bit15 and page bit9
// - program address is page low8 above address14:1, then page bit8
// - page bit8 selects lower or upper word
// - 512 valid pages 200h through 3FFh
// - 200h-2FFh lower words, 300h-3FFh upper words
// - upper data half maps onto any valid page
// - lower pages give even addresses, reads only
// - upper pages give odd addresses, reads only
// - window access with zero page traps
// - outside repeat: move plus one, others two
// - repeat edges and interrupt edges add two
// - other repeat iterations add nothing
// - page register is ten bits wide
// - program bit15 comes from page bit0
module psrw_window (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  // page registers
  input  wire logic                         pageWe,
  input  wire logic [psrw_pkg::PAGE_W-1:0]  pageWdata,
  input  wire logic [psrw_pkg::PAGE_W-1:0]  writePage,
  output logic      [psrw_pkg::PAGE_W-1:0]  readPage,
  // cpu access
  input  wire psrw_pkg::psrw_req_t          req,
  output psrw_pkg::psrw_rsp_t               rsp,
  output logic                              rspValid,
  // program flash read port
  input  wire logic [23:0]                  flashWord,
  output logic      [psrw_pkg::WORD_W-1:0]  readData
);
  import psrw_pkg::*;

  // ****************************************
  // page register
  // ****************************************
  logic [PAGE_W-1:0] page_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_reg <= PAGE_RST;
    end else if (pageWe) begin
      page_reg <= pageWdata;
    end
  end
  assign readPage = page_reg;

  // ****************************************
  // decode
  // ****************************************
  wire inWindow  = req.addr[WINDOW_BIT];
  wire pageOn    = page_reg[PAGE_EN_BIT];
  wire mapped    = inWindow && pageOn && !req.isWrite;
  wire pageValid = page_reg >= PAGE_FIRST;
  wire upperSel  = page_reg[PAGE_WSEL_BIT];
  wire readTrap  = inWindow && !req.isWrite && (page_reg == PAGE_RST);
  wire writeTrap = inWindow && req.isWrite && (writePage == PAGE_RST);
  wire trap      = readTrap || writeTrap;
  // page low bits above ea 14:0, page bit0 lands at bit 15
  wire [PROG_ADDR_W-1:0] wordAddr =
    {page_reg[PAGE_LOW_W-1:0], req.addr[WINDOW_BIT-1:0]};
  // even for lower words, odd for upper words
  wire [PROG_ADDR_W-1:0] progAddr =
    {wordAddr[PROG_ADDR_W-1:1], upperSel};

  wire repEdge = req.repFirst || req.repLast ||
                 req.repIntExit || req.repIntEntry;
  wire [1:0] extra =
    !mapped      ? EXTRA_NONE :
    !req.inRepeat ? (req.isMove ? EXTRA_MOVE : EXTRA_OTHER) :
    repEdge      ? EXTRA_OTHER :
                   EXTRA_NONE;

  psrw_rsp_t rspNext;
  always_comb begin
    rspNext             = '0;
    rspNext.toProgram   = mapped && pageValid && !trap;
    rspNext.toData      = !mapped && !trap;
    rspNext.addrTrap    = trap;
    rspNext.upperWord   = upperSel;
    rspNext.extraCycles = extra;
    rspNext.progAddr    = progAddr;
    rspNext.dataAddr    = req.addr;
  end

  // ****************************************
  // registered answer
  // ****************************************
  psrw_rsp_t rsp_reg;
  logic      valid_reg;
  logic [WORD_W-1:0] data_reg;
  // upper word: phantom byte reads as zero
  wire [WORD_W-1:0] flashSel = upperSel ? {8'h00, flashWord[23:16]}
                                        : flashWord[15:0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_reg   <= '0;
      valid_reg <= 1'b0;
      data_reg  <= '0;
    end else begin
      rsp_reg   <= req.valid ? rspNext : '0;
      valid_reg <= req.valid;
      data_reg  <= flashSel;
    end
  end
  assign rsp      = rsp_reg;
  assign rspValid = valid_reg;
  assign readData = data_reg;

  // ****************************************
  // checks: routing and traps
  // ****************************************
  route_cond_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rsp.toProgram |-> $past(req.valid) && $past(req.addr[WINDOW_BIT])
      && $past(page_reg[PAGE_EN_BIT]) && !$past(req.isWrite))
    else $error("program route without enable");
  trap_zero_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    req.valid && req.addr[WINDOW_BIT] && !req.isWrite && page_reg == PAGE_RST
    |=> rsp.addrTrap && !rsp.toProgram && !rsp.toData)
    else $error("zero page did not trap");
  write_trap_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    req.valid && req.addr[WINDOW_BIT] && req.isWrite && writePage == PAGE_RST
    |=> rsp.addrTrap && !rsp.toData)
    else $error("zero write page did not trap");
  write_nomap_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    req.valid && req.isWrite |=> !rsp.toProgram)
    else $error("write reached program");
  plain_data_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    req.valid && !req.addr[WINDOW_BIT]
    |=> rsp.toData && rsp.extraCycles == EXTRA_NONE)
    else $error("plain access delayed");
  nomap_data_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    req.valid && req.addr[WINDOW_BIT] && !req.isWrite
      && !page_reg[PAGE_EN_BIT] && page_reg != PAGE_RST
    |=> rsp.toData && !rsp.toProgram && rsp.extraCycles == EXTRA_NONE)
    else $error("disabled page left data path");

  // ****************************************
  // checks: address forming
  // ****************************************
  prog_high_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rsp.toProgram |-> rsp.progAddr[PROG_ADDR_W-1:WINDOW_BIT]
      == $past(page_reg[PAGE_LOW_W-1:0]))
    else $error("program page bits wrong");
  prog_addr_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rsp.toProgram |-> rsp.progAddr[WINDOW_BIT-1:1]
      == $past(req.addr[WINDOW_BIT-1:1]))
    else $error("program address low bits wrong");
  bit15_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rsp.toProgram |-> rsp.progAddr[WINDOW_BIT] == $past(page_reg[0]))
    else $error("program bit15 not page bit0");
  word_sel_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rsp.toProgram |-> rsp.progAddr[0] == $past(page_reg[PAGE_WSEL_BIT])
      && rsp.upperWord == rsp.progAddr[0])
    else $error("word select parity wrong");
  lower_page_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rsp.toProgram && !rsp.upperWord |-> $past(page_reg) >= PAGE_FIRST
      && $past(page_reg) <= PAGE_LOWER_HI)
    else $error("lower word from wrong page");
  upper_page_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rsp.toProgram && rsp.upperWord |-> $past(page_reg) >= PAGE_UPPER_LO
      && $past(page_reg) <= PAGE_LAST)
    else $error("upper word from wrong page");

  // ****************************************
  // checks: added cycles
  // ****************************************
  move_one_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    req.valid && mapped && !req.inRepeat && req.isMove
    |=> rsp.extraCycles == EXTRA_MOVE)
    else $error("move penalty not one");
  other_two_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    req.valid && mapped && !req.inRepeat && !req.isMove
    |=> rsp.extraCycles == EXTRA_OTHER)
    else $error("other penalty not two");
  rep_edge_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    req.valid && mapped && req.inRepeat && repEdge
    |=> rsp.extraCycles == EXTRA_OTHER)
    else $error("repeat edge penalty not two");
  rep_mid_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    req.valid && mapped && req.inRepeat && !repEdge
    |=> rsp.extraCycles == EXTRA_NONE)
    else $error("mid repeat penalty nonzero");

  // ****************************************
  // checks: page register and read data
  // ****************************************
  page_write_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    pageWe |=> readPage == $past(pageWdata))
    else $error("page write lost");
  page_hold_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    !pageWe |=> $stable(readPage))
    else $error("page changed without write");
  lower_data_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rsp.toProgram && !rsp.upperWord |-> readData == $past(flashWord[15:0]))
    else $error("lower word data wrong");
  upper_data_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rsp.toProgram && rsp.upperWord
    |-> readData == {8'h00, $past(flashWord[23:16])})
    else $error("upper word data wrong");

  // ****************************************
  // coverage
  // ****************************************
  lower_c: cover property (@(posedge clk) rsp.toProgram && !rsp.upperWord);
  upper_c: cover property (@(posedge clk) rsp.toProgram && rsp.upperWord);
  trap_c:  cover property (@(posedge clk) rsp.addrTrap);
  rep_c:   cover property (@(posedge clk)
    req.valid && mapped && req.inRepeat && !repEdge);
  move_c:  cover property (@(posedge clk)
    rsp.toProgram && rsp.extraCycles == EXTRA_MOVE);

endmodule

// ==== testbench/program_space_read_window_test.sv ====
`timescale 1ns/100ps
module program_space_read_window_test;
  import psrw_pkg::*;
  logic              clk, arst_n, pageWe, rspValid, expValid, mapped;
  logic [PAGE_W-1:0] pageWdata, writePage, readPage, pg;
  logic [23:0]       flashWord;
  logic [WORD_W-1:0] readData, expData;
  logic [15:0]       r, r2, lfsr;
  logic [3:0]        e4;
  psrw_req_t         req, q;
  psrw_rsp_t         rsp, expRsp;
  int                bad_count, tests_run;
  logic [PAGE_W-1:0] pages [8] = '{10'h000, 10'h0c5, 10'h200, 10'h2ff,
                                   10'h300, 10'h3ff, 10'h2a5, 10'h37e};

  psrw_window psrw_window_inst (.clk(clk), .arst_n(arst_n), .pageWe(pageWe),
    .pageWdata(pageWdata), .writePage(writePage), .readPage(readPage),
    .req(req), .rsp(rsp), .rspValid(rspValid), .flashWord(flashWord),
    .readData(readData));
  psrw_flash_model psrw_flash_model_inst (.page(readPage), .addr(req.addr),
    .word(flashWord));

  function automatic logic [15:0] lfsrStep(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #75000;
    bad_count++;
    finish_test;
  end

  initial begin
    arst_n = 1'b0;
    pageWe = 1'b0;
    pageWdata = '0;
    writePage = '0;
    req = '0;
    lfsr = 16'h8fe2;
    expValid = 1'b0;
    expRsp = '0;
    pg = PAGE_RST;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    chk("rspValid", 0, rspValid);
    for (int i = 0; i < 1500; i++) begin
      @(posedge clk);
      lfsr = lfsrStep(lfsr);
      r = lfsr;
      lfsr = lfsrStep(lfsr);
      r2 = lfsr;
      e4 = r[11] ? 4'h1 << r[13:12] : 4'h0;
      q = '0;
      q.valid = r[5] | r[6];
      q.isWrite = r[7] & r[8];
      q.isMove = r[9];
      q.inRepeat = r[10];
      q.addr = r2;
      {q.repFirst, q.repLast, q.repIntExit, q.repIntEntry} = e4;
      req <= q;
      pageWe <= r[0] & r[1];
      pageWdata <= pages[r[4:2]];
      // zero write page when bit 15 of r is set, 1a3h otherwise
      writePage <= r[15] ? 10'h000 : 10'h1a3;
      @(negedge clk);
      chk("rspValid", expValid, rspValid);
      chk("toProgram", expRsp.toProgram, rsp.toProgram);
      chk("toData", expRsp.toData, rsp.toData);
      chk("addrTrap", expRsp.addrTrap, rsp.addrTrap);
      chk("extra", expRsp.extraCycles, rsp.extraCycles);
      if (expRsp.toProgram) begin
        chk("progAddr", expRsp.progAddr, rsp.progAddr);
        chk("upperWord", expRsp.upperWord, rsp.upperWord);
        chk("readData", expData, readData);
      end
      if (expRsp.toData)
        chk("dataAddr", expRsp.dataAddr, rsp.dataAddr);
      chk("readPage", pg, readPage);
      mapped = q.valid & ~q.isWrite & q.addr[15] & pg[9];
      expValid = q.valid;
      expRsp = '0;
      expRsp.addrTrap = q.valid & q.addr[15]
                        & (q.isWrite ? writePage == '0 : pg == '0);
      expRsp.toProgram = mapped;
      expRsp.toData = q.valid & ~mapped & ~expRsp.addrTrap;
      expRsp.extraCycles = !mapped ? EXTRA_NONE
        : !q.inRepeat ? (q.isMove ? EXTRA_MOVE : EXTRA_OTHER)
        : (|e4 ? EXTRA_OTHER : EXTRA_NONE);
      expRsp.progAddr = {pg[7:0], q.addr[14:1], pg[8]};
      expRsp.upperWord = pg[8];
      expRsp.dataAddr = q.addr;
      expData = pg[8] ? {8'h00, pg[7:0]} : {q.addr[14:0], 1'b1};
      if (pageWe) pg = pageWdata;
    end
    finish_test;
  end
endmodule

// ==== testbench/psrw_flash_model.sv ====
`timescale 1ns/100ps
module psrw_flash_model (
  // lookup
  input  wire logic [9:0]  page,
  input  wire logic [15:0] addr,
  // answer
  output logic      [23:0] word
);
  // distinct word per location, answered at once
  assign word = {page[7:0], addr[14:0], 1'b1};
endmodule
